// *** design/tsp_timer.sv ***
// 8-bit timer/counter with shared prescaler behind a wishbone slave
`timescale 1ns/100ps
module tsp_timer
    import tsp_pkg::*;
(
    input  wire logic             clk_sys,        // 125 MHz oscillator clock
    input  wire logic             rst_n,          // async reset, active low
    input  wire logic             wb_cyc_i,       // wishbone cycle
    input  wire logic             wb_stb_i,       // wishbone strobe
    input  wire logic             wb_we_i,        // wishbone write
    input  wire logic [ADR_W-1:0] wb_adr_i,       // byte address
    input  wire logic [3:0]       wb_sel_i,       // byte lanes
    input  wire logic [31:0]      wb_dat_i,       // write data
    output logic      [31:0]      wb_dat_o,       // read data
    output logic                  wb_ack_o,       // transfer acknowledge
    input  wire logic             extCountInput,  // external count pin
    input  wire logic             wdtRawTick,     // watchdog oscillator level
    output logic                  overflowIrq,    // overflow interrupt request
    output logic                  wdtTick,        // one pulse per watchdog count
    output logic                  wdtCounterClear // pulse clearing watchdog counter
);

    tsp_phase_t  phase_q;
    logic        ack_q;
    logic [31:0] rdData_q;
    logic [7:0]  timerCount_q;
    logic [7:0]  intControl_q;
    logic [7:0]  optionCfg_q;
    logic [4:0]  portADir_q;
    logic        sleepMode_q;
    logic        wdtClrPulse_q;
    logic        irq_q;
    logic [1:0]  hold_q;
    logic        extPrev_q;
    logic        syncPrev_q;
    logic        wdtDivPrev_q;
    logic        rawPrev_q;
    logic        wdtTick_q;
    logic        wdtClr_q;
    logic [7:0]  regIndex;
    logic        busWrite;
    logic        wrCount;
    logic        phFour;
    logic        assignTimer;
    logic [2:0]  ratio;
    logic        extLevel;
    logic        extRise;
    logic        prescEdge;
    logic        prescClear;
    logic [7:0]  prescCount;
    logic        prescOut;
    logic        syncLevel;
    logic        syncRise;
    logic        useSyncPath;
    logic        tickEvent;
    logic        incPulse;
    logic        overflowEvt;
    logic        wdtDivLevel;
    logic [7:0]  readMux;

    // pick one prescaler bit; shared by the timer and watchdog taps
    function automatic logic scaleBit(input logic [7:0] cnt, input logic [2:0] idx);
        scaleBit = cnt[idx];
    endfunction

    // ==========================================
    // instruction cycle phases
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            phase_q <= PH_ONE;
        end else begin
            case (phase_q)
                PH_ONE:   phase_q <= PH_TWO;
                PH_TWO:   phase_q <= PH_THREE;
                PH_THREE: phase_q <= PH_FOUR;
                PH_FOUR:  phase_q <= PH_ONE;
                default:  phase_q <= PH_ONE;
            endcase
        end
    end

    assign phFour = (phase_q == PH_FOUR);

    // ==========================================
    // wishbone slave: ack one cycle after the strobe, writes on the ack edge
    assign regIndex = wb_adr_i[ADR_W-1:IDX_LSB];
    assign busWrite = wb_cyc_i & wb_stb_i & wb_we_i & ack_q & wb_sel_i[0];
    assign wrCount  = busWrite & (regIndex == IDX_TIMER_COUNT);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= wb_cyc_i & wb_stb_i & ~ack_q;
        end
    end

    // read mux; prescaler count never appears here
    always_comb begin
        readMux = 8'h00;
        case (regIndex)
            IDX_TIMER_COUNT:  readMux = timerCount_q;
            IDX_INT_CONTROL:  readMux = intControl_q;
            IDX_OPTION_CFG:   readMux = optionCfg_q;
            IDX_PORTA_DIR:    readMux = {3'h0, portADir_q};
            IDX_CORE_CONTROL: readMux = {7'h00, sleepMode_q};
            default:          readMux = 8'h00;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rdData_q <= 32'h0000_0000;
        end else if (wb_cyc_i & wb_stb_i & ~ack_q) begin
            rdData_q <= {READ_PAD, readMux};
        end
    end

    // ==========================================
    // plain configuration registers; assignment may change any time
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            optionCfg_q <= RST_OPTION_CFG;
            portADir_q  <= RST_PORTA_DIR;
            sleepMode_q <= 1'b0;
        end else if (busWrite) begin
            if (regIndex == IDX_OPTION_CFG) optionCfg_q <= wb_dat_i[7:0];
            if (regIndex == IDX_PORTA_DIR) portADir_q <= wb_dat_i[4:0];
            if (regIndex == IDX_CORE_CONTROL) sleepMode_q <= wb_dat_i[CORE_SLEEP_BIT];
        end
    end

    // watchdog clear command is write-one, self clearing
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wdtClrPulse_q <= 1'b0;
        end else begin
            wdtClrPulse_q <= busWrite & (regIndex == IDX_CORE_CONTROL) & wb_dat_i[CORE_WDCLR_BIT];
        end
    end

    // ==========================================
    // option decode
    // low five option bits
    assign assignTimer = ~optionCfg_q[OPT_ASSIGN_BIT];   // assignment polarity
    assign ratio       = optionCfg_q[OPT_RATIO_MSB:0];
    assign extLevel    = extCountInput ^ optionCfg_q[OPT_EDGE_BIT];
    assign extRise     = extLevel & ~extPrev_q;

    // ext level idles high under the reset config, so its history starts high: no false edge
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            extPrev_q    <= 1'b1;
            wdtDivPrev_q <= 1'b0;
            rawPrev_q    <= 1'b0;
        end else begin
            extPrev_q    <= extLevel;
            wdtDivPrev_q <= wdtDivLevel;
            rawPrev_q    <= wdtRawTick;
        end
    end

    // ==========================================
    // shared prescaler; source and clear follow the assignment
    // single prescaler, one owner
    assign prescEdge  = assignTimer ? (~sleepMode_q & (optionCfg_q[OPT_SOURCE_BIT] ? extRise : phFour))
                                    : (wdtRawTick & ~rawPrev_q & (ratio != 3'h0));
    // count write clears / watchdog clear
    assign prescClear = assignTimer ? wrCount : wdtClrPulse_q;

    tsp_prescaler u_prescaler (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .countEdge (prescEdge),
        .clear     (prescClear),
        .count     (prescCount)
    );

    // ratio tap is a symmetric divider / timer ratio 2^(ratio+1)
    // bypass when prescaler serves the watchdog
    assign prescOut = assignTimer ? scaleBit(prescCount, ratio) : extLevel;

    // ==========================================
    // phase synchroniser and edge detect
    // sample on phase two and four
    tsp_phase_sync u_sync (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .sampleNow ((phase_q == PH_TWO) | phFour),
        .levelIn   (prescOut),
        .levelOut  (syncLevel)
    );

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            syncPrev_q <= 1'b1;
        end else begin
            syncPrev_q <= syncLevel;
        end
    end

    assign syncRise    = syncLevel & ~syncPrev_q;
    // internal clock without prescaler needs no synchroniser
    assign useSyncPath = optionCfg_q[OPT_SOURCE_BIT] | assignTimer;
    assign tickEvent   = useSyncPath ? syncRise : phFour;
    // sleep stops counting / write hold-off
    assign incPulse    = tickEvent & ~sleepMode_q & (hold_q == 2'h0) & ~wrCount;
    assign overflowEvt = incPulse & (timerCount_q == COUNT_MAX);

    // ==========================================
    // hold-off: two instruction cycles blocked after a count write
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            hold_q <= 2'h0;
        end else if (wrCount) begin
            hold_q <= HOLD_CYCLES;
        end else if (phFour && hold_q != 2'h0) begin
            hold_q <= hold_q - 2'h1;
        end
    end

    // count register; a write wins over a coincident increment
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            timerCount_q <= RST_TIMER_COUNT;
        end else if (wrCount) begin
            timerCount_q <= wb_dat_i[7:0];
        end else if (incPulse) begin
            timerCount_q <= timerCount_q + 8'h01;
        end
    end

    // ==========================================
    // interrupt control; overflow set beats a software clear
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            intControl_q <= RST_INT_CONTROL;
        end else begin
            if (busWrite && regIndex == IDX_INT_CONTROL) intControl_q <= wb_dat_i[7:0];
            if (overflowEvt) intControl_q[INT_FLAG_BIT] <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= intControl_q[INT_FLAG_BIT] & intControl_q[INT_ENABLE_BIT];
        end
    end

    // ==========================================
    // watchdog postscaler: 2^ratio when assigned, raw otherwise
    // watchdog division
    assign wdtDivLevel = (~assignTimer && ratio != 3'h0) ? scaleBit(prescCount, ratio - 3'h1) : wdtRawTick;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wdtTick_q <= 1'b0;
            wdtClr_q  <= 1'b0;
        end else begin
            wdtTick_q <= wdtDivLevel & ~wdtDivPrev_q;
            wdtClr_q  <= wdtClrPulse_q;
        end
    end

    assign wb_dat_o        = rdData_q;
    assign wb_ack_o        = ack_q;
    assign overflowIrq     = irq_q;
    assign wdtTick         = wdtTick_q;
    assign wdtCounterClear = wdtClr_q;

    // ==========================================
    // checks
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    overflow_set_a: assert property (overflowEvt |=> intControl_q[INT_FLAG_BIT])
        else $error("overflow did not set flag");
    irq_mask_a: assert property (!intControl_q[INT_ENABLE_BIT] |=> !overflowIrq)
        else $error("masked overflow raised request");
    flag_sticky_a: assert property (intControl_q[INT_FLAG_BIT] && !(busWrite && regIndex == IDX_INT_CONTROL)
        |=> intControl_q[INT_FLAG_BIT])
        else $error("flag dropped without software clear");
    sleep_stop_a: assert property (sleepMode_q && !wrCount |=> $stable(timerCount_q))
        else $error("count moved during sleep");
    bypass_path_a: assert property (!assignTimer |-> prescOut == extLevel)
        else $error("bypass does not pass input");
    inc_after_sync_a: assert property (incPulse && useSyncPath |-> syncLevel && !$past(syncLevel))
        else $error("increment without synchronised edge");
    write_hold_a: assert property (wrCount |=> !incPulse [*5])
        else $error("increment inside write hold-off");
    presc_clear_a: assert property (wrCount && assignTimer |=> prescCount == 8'h00)
        else $error("count write did not clear prescaler");
    wdt_clear_a: assert property (wdtClrPulse_q && !assignTimer |=> prescCount == 8'h00 ##0 wdtCounterClear)
        else $error("watchdog clear missed");
    wdt_undivided_a: assert property (assignTimer && wdtRawTick && !wdtDivPrev_q |=> wdtTick)
        else $error("undivided watchdog tick lost");

endmodule

// *** design/tsp_pkg.sv ***
// constants shared by the timer, its prescaler and the phase synchroniser
package tsp_pkg;

    // ==========================================
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_TIMER_COUNT  = 8'h01;
    localparam logic [7:0] IDX_INT_CONTROL  = 8'h0b;
    localparam logic [7:0] IDX_OPTION_CFG   = 8'h81;
    localparam logic [7:0] IDX_PORTA_DIR    = 8'h85;
    localparam logic [7:0] IDX_CORE_CONTROL = 8'h90;

    // ==========================================
    // bus geometry
    localparam int         ADR_W     = 10;
    localparam int         IDX_LSB   = 2;
    localparam logic [23:0] READ_PAD = 24'h00_0000;

    // ==========================================
    // values after reset
    localparam logic [7:0] RST_TIMER_COUNT  = 8'h00;
    localparam logic [7:0] RST_INT_CONTROL  = 8'h00;
    localparam logic [7:0] RST_OPTION_CFG   = 8'hff;
    localparam logic [4:0] RST_PORTA_DIR    = 5'h1f;
    localparam logic [7:0] RST_PRESCALE     = 8'h00;

    // ==========================================
    // field positions
    localparam int OPT_SOURCE_BIT = 5;
    localparam int OPT_EDGE_BIT   = 4;
    localparam int OPT_ASSIGN_BIT = 3;
    localparam int OPT_RATIO_MSB  = 2;
    localparam int INT_ENABLE_BIT = 5;
    localparam int INT_FLAG_BIT   = 2;
    localparam int CORE_SLEEP_BIT = 0;
    localparam int CORE_WDCLR_BIT = 1;

    // ==========================================
    // counts
    localparam logic [7:0] COUNT_MAX   = 8'hff;
    localparam logic [1:0] HOLD_CYCLES = 2'h2;

    // ==========================================
    // instruction cycle phases, one clock each
    typedef enum logic [3:0] {
        PH_ONE   = 4'h1,
        PH_TWO   = 4'h2,
        PH_THREE = 4'h4,
        PH_FOUR  = 4'h8
    } tsp_phase_t;

endpackage

// *** design/tsp_phase_sync.sv ***
// two-stage synchroniser that samples only on the second and fourth phases
`timescale 1ns/100ps
module tsp_phase_sync
    import tsp_pkg::*;
(
    input  wire logic clk_sys,   // core clock
    input  wire logic rst_n,     // async reset, active low
    input  wire logic sampleNow, // high on phase two and phase four
    input  wire logic levelIn,   // prescaler output level
    output logic      levelOut   // synchronised level
);

    logic stageOne_q;
    logic stageTwo_q;

    // ==========================================
    // sampling chain; the first stage feeds only the second
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            stageOne_q <= 1'b1;
            stageTwo_q <= 1'b1;
        end else if (sampleNow) begin
            stageOne_q <= levelIn;
            stageTwo_q <= stageOne_q;
        end
    end

    assign levelOut = stageTwo_q;

endmodule

// *** design/tsp_prescaler.sv ***
// shared 8-bit prescaler counter, hidden from software
`timescale 1ns/100ps
module tsp_prescaler
    import tsp_pkg::*;
(
    input  wire logic       clk_sys,   // core clock
    input  wire logic       rst_n,     // async reset, active low
    input  wire logic       countEdge, // one-cycle pulse per source edge
    input  wire logic       clear,     // one-cycle clear pulse
    output logic [7:0]      count      // synchronous binary count, bits give the ratios
);

    logic [7:0] count_q;

    // ==========================================
    // counter; a clear beats a coincident edge so the restart is exact
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= RST_PRESCALE;
        end else if (clear) begin
            count_q <= RST_PRESCALE;
        end else if (countEdge) begin
            count_q <= count_q + 8'h01;
        end
    end

    assign count = count_q;

endmodule

// *** dv/tsp_ext_source.sv ***
// behavioural pulse source standing on the external count pin
`timescale 1ns/100ps
module tsp_ext_source (
    input  wire logic clk_sys,      // core clock
    output logic      extCountInput // count pin level
);
    // pin rests low between trains, as a driven clock pin would
    initial extCountInput = 1'b0;

    // ==========================================
    // pulse train
    // width and period respected
    // each level is held for half clocks, never under two, so phase sampling cannot miss it
    task automatic pulses(input int n, input int half);
        for (int i = 0; i < n; i++) begin
            @(posedge clk_sys);
            extCountInput <= 1'b1;
            repeat (half) @(posedge clk_sys);
            extCountInput <= 1'b0;
            repeat (half - 1) @(posedge clk_sys);
        end
    endtask
endmodule

// *** dv/test_tsp_timer.sv ***
// self-checking bench for the timer with shared prescaler
`timescale 1ns/100ps
`define CHK(nm, e, g) begin nChecks++; if ((g) !== (e)) begin miscompares++; \
    $display("FAIL %s expected %0h seen %0h", nm, e, g); end end
module test_tsp_timer;
    import tsp_pkg::*;
    logic             clk_sys, rst_n, wbCyc, wbStb, wbWe, wbAck, overflowIrq, wdtTick, wdtClr, rawTick;
    logic [ADR_W-1:0] wbAdr;
    logic [3:0]       wbSel;
    logic [31:0]      wbDatI, wbDatO;
    logic             extIn;
    logic [7:0]       va, vb;
    int               miscompares, nChecks, tickCnt, clrCnt, t0;

    tsp_timer i_dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
        .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatI), .wb_dat_o(wbDatO), .wb_ack_o(wbAck),
        .extCountInput(extIn), .wdtRawTick(rawTick), .overflowIrq(overflowIrq), .wdtTick(wdtTick),
        .wdtCounterClear(wdtClr)
    );
    tsp_ext_source i_src (.clk_sys(clk_sys), .extCountInput(extIn));

    // ==========================================
    // clock, time-zero values, pulse counters
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    initial begin
        {rst_n, wbCyc, wbStb, wbWe, rawTick} = 5'h00;
        wbAdr = '0;
        wbSel = 4'h0;
        wbDatI = 32'h0000_0000;
        miscompares = 0;
        nChecks = 0;
        tickCnt = 0;
        clrCnt = 0;
    end
    // counters only grow, so checks compare differences
    always @(posedge clk_sys) begin
        if (wdtTick === 1'b1) tickCnt <= tickCnt + 1;
        if (wdtClr === 1'b1) clrCnt <= clrCnt + 1;
    end

    // ==========================================
    // bus and stimulus tasks
    // one classic cycle; gap edge afterwards keeps cyc low a full cycle
    task automatic wbXfer(input logic we, input logic [7:0] idx, input logic [7:0] wd, output logic [7:0] rd);
        int n;
        n = 0;
        @(posedge clk_sys);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbSel <= 4'h1;
        wbAdr <= {idx, 2'b00};
        wbDatI <= {24'h00_0000, wd};
        do begin
            @(posedge clk_sys);
            n++;
        end while (wbAck !== 1'b1 && n < 20);
        if (n >= 20) begin
            miscompares++;
            conclude();
        end
        rd = wbDatO[7:0];
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        wbWe <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
        logic [7:0] dummy;
        wbXfer(1'b1, idx, wd, dummy);
    endtask
    task automatic rdChk(input logic [7:0] idx, input logic [7:0] exp, input string nm);
        logic [7:0] v;
        wbXfer(1'b0, idx, 8'h00, v);
        `CHK(nm, exp, v)
    endtask
    // raw watchdog oscillator edges, three clocks per level
    task automatic rawEdges(input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk_sys);
            rawTick <= 1'b1;
            repeat (3) @(posedge clk_sys);
            rawTick <= 1'b0;
            repeat (2) @(posedge clk_sys);
        end
    endtask
    task automatic conclude();
        if (miscompares == 0 && nChecks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ==========================================
    // hang guard
    initial begin
        repeat (60000) @(posedge clk_sys);
        miscompares++;
        conclude();
    end

    // ==========================================
    // main sequence
    initial begin
        repeat (10) @(posedge clk_sys);
        rst_n <= 1'b1;
        rdChk(IDX_OPTION_CFG, 8'hff, "option reset");
        rdChk(IDX_INT_CONTROL, 8'h00, "intctl reset");
        rdChk(IDX_PORTA_DIR, 8'h1f, "portdir reset");
        wr(IDX_PORTA_DIR, 8'hff);
        rdChk(IDX_PORTA_DIR, 8'h1f, "portdir width");
        wr(8'h40, 8'h5a);
        rdChk(8'h40, 8'h00, "unmapped");
        // internal source, prescaler kept by the watchdog
        wr(IDX_OPTION_CFG, 8'h08);
        wr(IDX_TIMER_COUNT, 8'h00);
        rdChk(IDX_TIMER_COUNT, 8'h00, "write holdoff");
        wbXfer(1'b0, IDX_TIMER_COUNT, 8'h00, va);
        repeat (36) @(posedge clk_sys);
        wbXfer(1'b0, IDX_TIMER_COUNT, 8'h00, vb);
        `CHK("rate", 8'h0a, vb - va)
        // sleep freezes the count
        wr(IDX_CORE_CONTROL, 8'h01);
        wbXfer(1'b0, IDX_TIMER_COUNT, 8'h00, va);
        repeat (36) @(posedge clk_sys);
        wbXfer(1'b0, IDX_TIMER_COUNT, 8'h00, vb);
        `CHK("sleep", va, vb)
        wr(IDX_CORE_CONTROL, 8'h00);
        // overflow flag, mask and software clear
        wr(IDX_INT_CONTROL, 8'h20);
        wr(IDX_TIMER_COUNT, 8'hfe);
        repeat (40) @(posedge clk_sys);
        rdChk(IDX_INT_CONTROL, 8'h24, "flag set");
        `CHK("irq on", 1'b1, overflowIrq)
        wr(IDX_INT_CONTROL, 8'h04);
        repeat (2) @(posedge clk_sys);
        `CHK("irq masked", 1'b0, overflowIrq)
        rdChk(IDX_INT_CONTROL, 8'h04, "flag held");
        wr(IDX_INT_CONTROL, 8'h00);
        rdChk(IDX_INT_CONTROL, 8'h00, "flag clear");
        // external input, undivided, rising then falling edges
        for (int e = 0; e < 2; e++) begin
            wr(IDX_OPTION_CFG, e ? 8'h38 : 8'h28);
            wr(IDX_TIMER_COUNT, 8'h00);
            repeat (8) @(posedge clk_sys);                    // let the write hold-off expire
            i_src.pulses(5, 4);
            repeat (10) @(posedge clk_sys);
            rdChk(IDX_TIMER_COUNT, 8'h05, "ext direct");
        end
        // every timer ratio; count write clears a stale prescaler
        for (int r = 0; r < 8; r++) begin
            wr(IDX_CORE_CONTROL, 8'h02);
            wr(IDX_OPTION_CFG, 8'h20 | r[7:0]);
            wr(IDX_TIMER_COUNT, 8'h00);
            repeat (8) @(posedge clk_sys);                    // let the write hold-off expire
            i_src.pulses(4 << r, 3);
            repeat (10) @(posedge clk_sys);
            rdChk(IDX_TIMER_COUNT, 8'h02, "ext divided");
        end
        // hand the prescaler back to the watchdog
        wr(IDX_CORE_CONTROL, 8'h02);
        wr(IDX_TIMER_COUNT, 8'h00);
        wr(IDX_OPTION_CFG, 8'h0f);
        wr(IDX_CORE_CONTROL, 8'h02);
        for (int r = 0; r < 4; r++) begin
            wr(IDX_OPTION_CFG, 8'h08 | r[7:0]);
            t0 = tickCnt;
            rawEdges(8);
            `CHK("wdt ratio", 8 >> r, tickCnt - t0)
        end
        t0 = clrCnt;
        wr(IDX_CORE_CONTROL, 8'h02);
        repeat (4) @(posedge clk_sys);
        `CHK("wdt clear", 1, clrCnt - t0)
        wr(IDX_OPTION_CFG, 8'h0a);
        rawEdges(3);
        wr(IDX_CORE_CONTROL, 8'h02);
        t0 = tickCnt;
        rawEdges(2);
        `CHK("wdt prescale clr", 1, tickCnt - t0)
        wr(IDX_OPTION_CFG, 8'h22);
        t0 = tickCnt;
        rawEdges(3);
        `CHK("wdt undivided", 3, tickCnt - t0)
        conclude();
    end
endmodule
